// File: pkg/scs_pkg.sv
// Shared constants, timing counts and state codes of the serial configuration sequencer.
package scs_pkg;

    // ********************
    // Rates and widths
    // ********************
    localparam int REF_MHZ    = 250;
    localparam int REF_KHZ    = REF_MHZ * 1000;
    localparam int CNT_W      = 20;
    localparam int BYTE_W     = 8;
    localparam int FIFO_DEPTH = 32;

    // ********************
    // Reset handshake times
    // ********************
    localparam int T_CF2CD_NS      = 600;
    localparam int CF2CD_CYC       = T_CF2CD_NS * REF_MHZ / 1000;
    localparam int T_CF2ST0_NS     = 600;
    localparam int CF2ST0_CYC      = T_CF2ST0_NS * REF_MHZ / 1000;
    localparam int T_STATUS_MIN_US = 268;
    localparam int STATUS_MIN_CYC  = T_STATUS_MIN_US * REF_MHZ;

    // ********************
    // Initialization times
    // ********************
    localparam int T_CD2UM_MIN_US = 175;
    localparam int INIT_MIN_CYC   = T_CD2UM_MIN_US * REF_MHZ;
    localparam int T_CD2UM_MAX_US = 830;
    localparam int INIT_MAX_CYC   = T_CD2UM_MAX_US * REF_MHZ;
    localparam int OSC_KHZ        = 12500;
    localparam int OSC_DIV        = (REF_KHZ + OSC_KHZ - 1) / OSC_KHZ;
    localparam int INIT_CLKS      = 600;
    localparam int INIT_OSC_CYC   = (INIT_MIN_CYC > INIT_CLKS * OSC_DIV) ?
                                    INIT_MIN_CYC : INIT_CLKS * OSC_DIV;
    localparam int PS_FMAX_KHZ    = 125000;
    localparam int CU_PERIODS     = 4;
    localparam int CD2CU_CYC      = (CU_PERIODS * REF_KHZ + PS_FMAX_KHZ - 1) / PS_FMAX_KHZ;

    // ********************
    // Active serial clock and header
    // ********************
    localparam int AS_F0_KHZ = 12500;
    localparam int AS_F1_KHZ = 25000;
    localparam int AS_F2_KHZ = 50000;
    localparam int AS_F3_KHZ = 100000;
    localparam logic [3:0] AS_HALF0 = 4'((REF_KHZ + 2 * AS_F0_KHZ - 1) / (2 * AS_F0_KHZ));
    localparam logic [3:0] AS_HALF1 = 4'((REF_KHZ + 2 * AS_F1_KHZ - 1) / (2 * AS_F1_KHZ));
    localparam logic [3:0] AS_HALF2 = 4'((REF_KHZ + 2 * AS_F2_KHZ - 1) / (2 * AS_F2_KHZ));
    localparam logic [3:0] AS_HALF3 = 4'((REF_KHZ + 2 * AS_F3_KHZ - 1) / (2 * AS_F3_KHZ));
    localparam int          AS_HDR_BITS   = 32;
    localparam logic [5:0]  AS_HDR_FALLS  = 6'h20;
    localparam logic [7:0]  AS_READ_CMD   = 8'h03;
    localparam logic [23:0] AS_START_ADDR = 24'h00_0000;

    // Sequencer states, Gray coded along the configuration path.
    typedef enum logic [2:0] {
        ST_CLEAR   = 3'b000,
        ST_RELEASE = 3'b001,
        ST_LOAD    = 3'b011,
        ST_INIT    = 3'b010,
        ST_USER    = 3'b110,
        ST_ERROR   = 3'b111
    } scs_state_e;

endpackage

// File: verilog/scs_fifo.sv
// Synchronous first-in first-out buffer built from flip-flops.
`timescale 1ns/1ps
module scs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  logic             clk,
    input  logic             rst,
    input  logic             in_valid,
    output logic             in_ready,
    input  logic [WIDTH-1:0] in_data,
    output logic             out_valid,
    input  logic             out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             full;
    logic             empty;

    // Pointers carry one extra bit so that full and empty differ.
    assign empty     = (wr_q == rd_q);
    assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_q[rd_q[AW-1:0]];

    // Storage is written only when a word is accepted.
    always_ff @(posedge clk)
    begin
        if (in_valid && !full)
            mem_q[wr_q[AW-1:0]] <= in_data;
    end

    // Pointers advance on accepted pushes and pops.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (in_valid && !full)
                wr_q <= wr_q + 1'b1;
            if (out_ready && !empty)
                rd_q <= rd_q + 1'b1;
        end
    end

endmodule // scs_fifo

// File: verilog/scs_link.sv
// Link-side deserializer that shifts passive serial data in on the configuration clock.
`timescale 1ns/1ps
module scs_link (
    input  logic                       config_clock,
    input  logic                       load_en,
    input  logic                       ps_data,
    output logic [scs_pkg::BYTE_W-1:0] byte_data,
    output logic                       byte_toggle
);
    import scs_pkg::*;

    logic              en1_q;
    logic              en_q;
    logic [2:0]        bit_q;
    logic [BYTE_W-2:0] shift_q;
    logic [BYTE_W-1:0] byte_q;
    logic              tog_q;

    // Two-stage synchroniser for the load enable from the core clock.
    always_ff @(posedge config_clock)
    begin
        en1_q <= load_en;
        en_q  <= en1_q;
    end

    // Bits are taken on each rising edge while loading, first bit to the top.
    always_ff @(posedge config_clock)
    begin
        if (!en_q)
        begin
            bit_q   <= '0;
            shift_q <= '0;
        end
        else
        begin
            shift_q <= {shift_q[BYTE_W-3:0], ps_data};
            bit_q   <= bit_q + 3'h1;
        end
    end

    // A full byte is held and announced by flipping the toggle.
    always_ff @(posedge config_clock)
    begin
        if (!en_q)
            tog_q <= 1'b0;
        else if (bit_q == 3'h7)
        begin
            byte_q <= {shift_q, ps_data};
            tog_q  <= !tog_q;
        end
    end

    assign byte_data   = byte_q;
    assign byte_toggle = tog_q;

    ps_byte_a: assert property (@(posedge config_clock)
        en_q && bit_q == 3'h7 |=> byte_q[0] == $past(ps_data) && tog_q != $past(tog_q))
        else $error("Serial byte not completed on the eighth rising edge.");

endmodule // scs_link

// File: verilog/scs_top.sv
// Serial configuration sequencer: reset handshake, bitstream loading and initialization.
`timescale 1ns/1ps
module scs_top #(
    parameter int          STATUS_LOW_CYC  = scs_pkg::STATUS_MIN_CYC,
    parameter int          INIT_OSC_LEN    = scs_pkg::INIT_OSC_CYC,
    parameter int          INIT_MAX_LEN    = scs_pkg::INIT_MAX_CYC,
    parameter logic [23:0] BITSTREAM_BYTES = 24'h00_1000
) (
    input  logic                       ref_clk,
    input  logic                       rst,
    input  logic                       config_clock,
    input  logic                       ps_data,
    input  logic                       config_request_n,
    input  logic                       status_n_in,
    output logic                       status_n_out,
    output logic                       status_n_oe_n,
    output logic                       config_done,
    input  logic                       as_mode,
    input  logic [1:0]                 as_clk_sel,
    input  logic                       as_multi_device,
    input  logic                       user_clk_enable,
    input  logic                       user_init_clock,
    output logic                       config_clock_out,
    output logic                       flash_cs_n,
    output logic                       serial_cmd_out,
    input  logic                       as_data_in,
    output logic [scs_pkg::BYTE_W-1:0] cfg_data,
    output logic                       cfg_valid,
    input  logic                       cfg_ready,
    output logic                       user_mode
);
    import scs_pkg::*;

    localparam logic [CNT_W-1:0] STATUS_LAST = CNT_W'(STATUS_LOW_CYC - 1);
    localparam logic [CNT_W-1:0] INIT_LAST   = CNT_W'(INIT_OSC_LEN - 1);
    localparam logic [CNT_W-1:0] INIT_MAX    = CNT_W'(INIT_MAX_LEN);
    localparam logic [CNT_W-1:0] CU_LAST     = CNT_W'(CD2CU_CYC - 1);
    localparam logic [9:0]       UCLK_COUNT  = 10'(INIT_CLKS + 1); // Edges bound full periods.

    scs_state_e             state_q;
    scs_state_e             state_d;
    logic [8:0]             sync1_q;
    logic [8:0]             sync_q;
    logic                   req_s;
    logic                   status_s;
    logic                   as_din_s;
    logic                   uclk_s;
    logic                   uclk_prev_q;
    logic [CNT_W-1:0]       cnt_q;
    logic [CNT_W-1:0]       done_cnt_q;
    logic                   mode_q;
    logic                   multi_q;
    logic                   uopt_q;
    logic [3:0]             half_q;
    logic [3:0]             div_q;
    logic [9:0]             ucnt_q;
    logic [23:0]            byte_cnt_q;
    logic                   ps_en_q;
    logic [BYTE_W-1:0]      link_byte;
    logic                   link_tog;
    logic                   tog1_q;
    logic                   tog2_q;
    logic                   tog3_q;
    logic                   ps_stb;
    logic                   as_load;
    logic                   as_tick;
    logic                   as_fall;
    logic                   as_stb;
    logic [AS_HDR_BITS-1:0] hdr_q;
    logic [5:0]             hdr_left_q;
    logic [2:0]             as_bits_q;
    logic [BYTE_W-2:0]      as_sr_q;
    logic                   push_valid;
    logic                   push_ready;
    logic                   last_byte;
    logic                   fifo_clr;
    logic [BYTE_W-1:0]      push_data;
    logic                   clk_q;
    logic                   cs_n_q;
    logic                   cmd_q;
    logic                   done_q;
    logic                   oe_n_q;
    logic                   user_q;

    // ********************
    // Pin synchronisers
    // ********************

    // The request, status, flash data and user clock pins and every strap pass two flip-flops before use.
    always_ff @(posedge ref_clk)
    begin
        sync1_q     <= {user_clk_enable, as_multi_device, as_clk_sel, as_mode,
                        user_init_clock, as_data_in, status_n_in, config_request_n};
        sync_q      <= sync1_q;
        uclk_prev_q <= sync_q[3];
    end

    assign req_s    = sync_q[0];
    assign status_s = sync_q[1];
    assign as_din_s = sync_q[2];
    assign uclk_s   = sync_q[3];

    // ********************
    // Sequencer
    // ********************

    // A low request restarts everything; otherwise the path runs in order.
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_CLEAR:
                if (req_s && cnt_q >= STATUS_LAST)
                    state_d = ST_RELEASE;
            ST_RELEASE:
                if (status_s)
                    state_d = ST_LOAD;
            ST_LOAD:
            begin
                if (ps_stb && !push_ready)
                    state_d = ST_ERROR;
                else if (push_valid && push_ready && last_byte)
                    state_d = ST_INIT;
            end
            ST_INIT:
            begin
                if (uopt_q ? (ucnt_q == UCLK_COUNT) : (cnt_q >= INIT_LAST))
                    state_d = ST_USER;
            end
            ST_USER:
                state_d = ST_USER;
            ST_ERROR:
                state_d = ST_ERROR;
            default:
                state_d = ST_ERROR;
        endcase
        if (!req_s)
            state_d = ST_CLEAR;
    end

    // State register and a saturating cycle counter cleared on each move.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_q <= ST_CLEAR;
            cnt_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            if (state_d != state_q)
                cnt_q <= '0;
            else if (cnt_q != '1)
                cnt_q <= cnt_q + 1'b1;
        end
    end

    // Pin levels follow the next state so a request reaches them in one edge.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            oe_n_q <= 1'b0;
            done_q <= 1'b0;
            user_q <= 1'b0;
        end
        else
        begin
            oe_n_q <= !(state_d == ST_CLEAR || state_d == ST_ERROR);
            done_q <= (state_d == ST_INIT || state_d == ST_USER);
            user_q <= (state_d == ST_USER);
        end
    end

    // Straps are caught while the device is being cleared.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            mode_q  <= 1'b0;
            multi_q <= 1'b0;
            uopt_q  <= 1'b0;
            half_q  <= AS_HALF0;
        end
        else if (state_q == ST_CLEAR)
        begin
            mode_q  <= sync_q[4];
            multi_q <= sync_q[7];
            uopt_q  <= sync_q[8];
            unique case (sync_q[6:5])
                2'b00:   half_q <= AS_HALF0;
                2'b01:   half_q <= AS_HALF1;
                2'b10:   half_q <= AS_HALF2;
                2'b11:   half_q <= sync_q[7] ? AS_HALF2 : AS_HALF3;
            endcase
        end
    end

    // ********************
    // Passive serial crossing
    // ********************

    // Load enable goes out as a level; byte toggles come back through two flops.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ps_en_q <= 1'b0;
            tog1_q  <= 1'b0;
            tog2_q  <= 1'b0;
            tog3_q  <= 1'b0;
        end
        else
        begin
            ps_en_q <= (state_d == ST_LOAD) && !mode_q;
            tog1_q  <= link_tog;
            tog2_q  <= tog1_q;
            tog3_q  <= tog2_q;
        end
    end

    assign ps_stb = (tog2_q ^ tog3_q) && (state_q == ST_LOAD) && !mode_q;

    scs_link u_link (
        .config_clock (config_clock),
        .load_en      (ps_en_q),
        .ps_data      (ps_data),
        .byte_data    (link_byte),
        .byte_toggle  (link_tog)
    );

    // ********************
    // Active serial engine
    // ********************

    // The clock stalls while the buffer is full, so no flash byte is lost.
    assign as_load = (state_q == ST_LOAD) && mode_q;
    assign as_tick = as_load && push_ready && (div_q == half_q - 4'h1);
    assign as_fall = as_tick && clk_q;
    assign as_stb  = as_fall && (hdr_left_q == '0) && (as_bits_q == 3'h7);

    // Divider that makes the generated configuration clock.
    always_ff @(posedge ref_clk)
    begin
        if (rst || !as_load)
        begin
            div_q <= '0;
            clk_q <= 1'b0;
        end
        else if (push_ready)
        begin
            if (div_q == half_q - 4'h1)
            begin
                div_q <= '0;
                clk_q <= !clk_q;
            end
            else
                div_q <= div_q + 4'h1;
        end
    end

    // Read command goes out first, then flash data is shifted in.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            cs_n_q <= 1'b1;
        else
            cs_n_q <= !as_load;
        if (rst || !as_load)
        begin
            hdr_q      <= {AS_READ_CMD, AS_START_ADDR};
            cmd_q      <= AS_READ_CMD[7];
            hdr_left_q <= AS_HDR_FALLS;
            as_bits_q  <= '0;
            as_sr_q    <= '0;
        end
        else if (as_fall)
        begin
            if (hdr_left_q != '0)
            begin
                hdr_left_q <= hdr_left_q - 6'h01;
                hdr_q      <= {hdr_q[AS_HDR_BITS-2:0], 1'b0};
                cmd_q      <= hdr_q[AS_HDR_BITS-2];
            end
            else
            begin
                as_sr_q   <= {as_sr_q[BYTE_W-3:0], as_din_s};
                as_bits_q <= as_bits_q + 3'h1;
            end
        end
    end

    // ********************
    // Byte path and buffer
    // ********************

    assign push_valid = ps_stb || as_stb;
    assign push_data  = mode_q ? {as_sr_q, as_din_s} : link_byte;
    assign last_byte  = (byte_cnt_q == BITSTREAM_BYTES - 24'h00_0001);
    assign fifo_clr   = rst || (state_q == ST_CLEAR);

    // Counts accepted bytes of the current bitstream.
    always_ff @(posedge ref_clk)
    begin
        if (fifo_clr)
            byte_cnt_q <= '0;
        else if (push_valid && push_ready)
            byte_cnt_q <= byte_cnt_q + 24'h00_0001;
    end

    scs_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (ref_clk),
        .rst       (fifo_clr),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (cfg_valid),
        .out_ready (cfg_ready),
        .out_data  (cfg_data)
    );

    // ********************
    // Initialization
    // ********************

    // User clock edges count only after the enable delay has passed.
    always_ff @(posedge ref_clk)
    begin
        if (rst || state_q != ST_INIT)
            ucnt_q <= '0;
        else if (cnt_q >= CU_LAST && uclk_s && !uclk_prev_q && ucnt_q != UCLK_COUNT)
            ucnt_q <= ucnt_q + 10'h001;
    end

    // Cycles since done rose, kept for the timing checks below.
    always_ff @(posedge ref_clk)
    begin
        if (rst || !done_q)
            done_cnt_q <= '0;
        else if (done_cnt_q != '1)
            done_cnt_q <= done_cnt_q + 1'b1;
    end

    // Open-drain status pin only ever pulls low.
    assign status_n_out     = 1'b0;
    assign status_n_oe_n    = oe_n_q;
    assign config_done      = done_q;
    assign user_mode        = user_q;
    assign config_clock_out = clk_q;
    assign flash_cs_n       = cs_n_q;
    assign serial_cmd_out   = cmd_q;

    // ********************
    // Checks
    // ********************

    done_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(req_s) |=> !config_done ##1 !config_done)
        else $error("Done not low after a configuration request.");

    status_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(req_s) |=> !status_n_oe_n)
        else $error("Status not pulled low after a configuration request.");

    status_min_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(status_n_oe_n) |-> $past(cnt_q) >= STATUS_LAST && $past(state_q) == ST_CLEAR)
        else $error("Status low pulse shorter than its minimum.");

    release_a: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == ST_CLEAR && req_s && cnt_q >= STATUS_LAST |=> status_n_oe_n)
        else $error("Status not released once the low pulse was complete.");

    as_cmd_a: assert property (@(posedge ref_clk) disable iff (rst)
        !flash_cs_n && $changed(serial_cmd_out) |-> $fell(config_clock_out))
        else $error("Command output changed away from a falling clock edge.");

    as_sample_a: assert property (@(posedge ref_clk) disable iff (rst)
        as_fall && hdr_left_q == '0 |=> $fell(config_clock_out)
            && as_bits_q == $past(as_bits_q) + 3'h1)
        else $error("Flash data not sampled at the falling clock edge.");

    init_osc_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(user_mode) && !uopt_q |-> done_cnt_q > INIT_LAST && done_cnt_q <= INIT_MAX)
        else $error("Oscillator initialization time out of range.");

    init_user_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(user_mode) && uopt_q |-> $past(ucnt_q) == UCLK_COUNT && done_cnt_q > CU_LAST)
        else $error("User clock initialization ended early.");

    as_multi_a: assert property (@(posedge ref_clk) disable iff (rst)
        as_load && multi_q |-> half_q != AS_HALF3)
        else $error("Fastest clock setting used in a multi-device chain.");

    done_full_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(config_done) |-> byte_cnt_q == BITSTREAM_BYTES && state_q == ST_INIT)
        else $error("Done rose before the whole bitstream arrived.");

    ps_user_c: cover property (@(posedge ref_clk) disable iff (rst)
        $rose(user_mode) && !mode_q);

    as_user_c: cover property (@(posedge ref_clk) disable iff (rst)
        $rose(user_mode) && mode_q);

    overflow_c: cover property (@(posedge ref_clk) disable iff (rst)
        state_q == ST_ERROR);

    as_stall_c: cover property (@(posedge ref_clk) disable iff (rst)
        as_load && !push_ready);

endmodule // scs_top

// File: dv/scs_host_model.sv
// Far-side models: passive serial host and a serial flash answering the read header.
`timescale 1ns/1ps
module scs_host_model (
    output logic config_clock,
    output logic ps_data,
    input  logic flash_clk,
    output logic flash_data
);
    // The clock stands still low outside frames; the flash line starts high and then holds the last bit given.
    // This host watches status, so the longer blind wait of a host that does not is unused.
    initial
    begin
        config_clock = 1'b0;
        ps_data      = 1'b0;
        flash_data   = 1'b1;
    end
    // Skips header falls, then gives one byte MSB first, changed after each fall.
    task automatic flash_byte(input logic [7:0] b, input int skip);
        repeat (skip) @(negedge flash_clk);
        for (int k = 7; k >= 0; k--)
        begin
            flash_data <= b[k];
            @(negedge flash_clk);
        end
    endtask
    // Gives clock edges with no data so the link synchroniser fills.
    task automatic idle_edges(input int n);
        repeat (n)
        begin
            #4 config_clock = 1'b1;
            #4 config_clock = 1'b0;
        end
    endtask
    // Shifts one byte MSB first at 125 MHz; the line then shows the inverse.
    task automatic send_byte(input logic [7:0] b);
        for (int k = 7; k >= 0; k--)
        begin
            ps_data = b[k];
            #4 config_clock = 1'b1;
            #4 config_clock = 1'b0;
        end
        ps_data = ~b[0];
    endtask
endmodule // scs_host_model

// File: dv/testbench.sv
// Self-checking bench for the serial configuration sequencer.
`timescale 1ns/1ps
module testbench;
    localparam int SL = 40;
    localparam int IL = 60;
    // User clock period is 4 core cycles; least delay is the enable delay plus 600 periods.
    localparam int U0 = scs_pkg::CD2CU_CYC + scs_pkg::INIT_CLKS * 4;
    logic [1:0] sel;
    logic       multi, uopt, uclk, asd;
    time        tt;
    logic       ref_clk, rst, req_n, as_mode, ready;
    logic       cc, psd, st_out, st_oe_n, done, cco, cs_n, cmd, vld, um;
    logic [7:0] dat, hdr;
    logic [7:0] rows [16];
    int         err_total, checked, i, n;
    // The status wire is pulled up unless the device pulls it low.
    wire st_wire = (st_oe_n === 1'b0) ? st_out : 1'b1;

    scs_host_model scs_host_model_i (.config_clock(cc), .ps_data(psd), .flash_clk(cco),
        .flash_data(asd));
    scs_top #(.STATUS_LOW_CYC(SL), .INIT_OSC_LEN(IL), .INIT_MAX_LEN(200),
        .BITSTREAM_BYTES(24'h00_0010)) scs_top_i (
        .ref_clk(ref_clk), .rst(rst), .config_clock(cc), .ps_data(psd),
        .config_request_n(req_n), .status_n_in(st_wire), .status_n_out(st_out),
        .status_n_oe_n(st_oe_n), .config_done(done), .as_mode(as_mode),
        .as_clk_sel(sel), .as_multi_device(multi), .user_clk_enable(uopt),
        .user_init_clock(uclk), .config_clock_out(cco), .flash_cs_n(cs_n),
        .serial_cmd_out(cmd), .as_data_in(asd), .cfg_data(dat), .cfg_valid(vld),
        .cfg_ready(ready), .user_mode(um));

    // Core clock at 250 MHz.
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Free-running user init clock at 62.5 MHz, below its 100 MHz limit.
    initial
    begin
        uclk = 1'b0;
        forever #8 uclk = ~uclk;
    end
    // Compares a seen value with the expected one.
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
        checked++;
        if (s !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Watchdog cuts a hang short.
    initial
    begin
        #100000;
        err_total++;
        wrap_up();
    end
    // Main sequence.
    initial
    begin
        rst = 1'b1; req_n = 1'b1; as_mode = 1'b0; ready = 1'b0;
        sel = 2'b00; multi = 1'b0; uopt = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("done_rst", 8'h00, done);
        check("oe_rst", 8'h00, st_oe_n);
        rst = 1'b0;
        repeat (SL - 5) @(negedge ref_clk);
        check("st_min", 8'h00, st_oe_n);
        repeat (20) @(negedge ref_clk);
        check("st_rel", 8'h01, st_oe_n);
        $display("test reset done");
        repeat (2550) @(negedge ref_clk); // 10 us after status rises
        scs_host_model_i.idle_edges(2);
        // Rows: each byte sent is also the byte expected at the FIFO head.
        for (i = 0; i < 16; i++)
        begin
            rows[i] = 8'h5a ^ 8'(i * 37);
            if (i == 15)
                check("done_early", 8'h00, done);
            scs_host_model_i.send_byte(rows[i]);
        end
        for (i = 0; i < 40 && done !== 1'b1; i++) @(negedge ref_clk);
        check("done_end", 8'h01, done);
        for (n = 0; n < 250 && um !== 1'b1; n++) @(negedge ref_clk);
        check("init_len", 8'(IL), 8'(n));
        ready = 1'b1;
        for (i = 0; i < 16; i++)
        begin
            check("byte", rows[i], dat);
            @(negedge ref_clk);
        end
        check("empty", 8'h00, vld);
        $display("test passive load done");
        req_n = 1'b0; as_mode = 1'b1; ready = 1'b0;
        sel = 2'b11; multi = 1'b1; uopt = 1'b1;
        for (n = 0; n < 200 && (done !== 1'b0 || st_oe_n !== 1'b0); n++) @(negedge ref_clk);
        check("cf2cd", 8'h01, 8'(n <= 150));
        repeat (500) @(negedge ref_clk); // 2 us low pulse
        check("um_clr", 8'h00, um);
        req_n = 1'b1;
        for (n = 0; n < 100 && st_oe_n !== 1'b1; n++) @(negedge ref_clk);
        check("st_again", 8'h01, st_oe_n);
        repeat (8)
        begin
            @(posedge cco);
            hdr = {hdr[6:0], cmd};
        end
        tt = $time;
        @(posedge cco);
        check("as_period", 8'(2 * scs_pkg::AS_HALF2), 8'(($time - tt) / 4));
        check("cs_low", 8'h00, cs_n);
        check("as_cmd", 8'h03, hdr);
        $display("test active header done");
        scs_host_model_i.flash_byte(8'h96, 24);
        @(negedge ref_clk);
        check("as_byte", 8'h96, dat);
        for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge ref_clk);
        check("as_done", 8'h01, done);
        for (n = 0; n < 3000 && um !== 1'b1; n++) @(negedge ref_clk);
        check("uclk_len", 8'h01, 8'(n >= U0 && n <= U0 + 8));
        $display("test active load done");
        wrap_up();
    end
endmodule // testbench
